// ---- design/isp_defines.vh ----
// constants for the interrupt status / priority control block
// assumes a 16-bit register port and a single system clock
`ifndef ISP_DEFINES_VH
`define ISP_DEFINES_VH

`define ISP_ADDR_STATUS 16'h70a0
`define ISP_ADDR_ROUTE 16'h70a4
`define ISP_ADDR_MISC 16'h70a8
`define ISP_ROUTE_RST 16'h0000
`define ISP_MISC_RST 16'h0000
// writable bits of the route and misc words
`define ISP_ROUTE_WMASK 16'heff7
`define ISP_MISC_WMASK 16'hf800
// write-one-to-clear bits of the status word
`define ISP_STATUS_W1C 16'h9800
// status / route bit positions
`define ISP_B_KEY 15
`define ISP_B_UART 14
`define ISP_B_SPI 13
`define ISP_B_EXT1 12
`define ISP_B_EXT0 11
`define ISP_B_ADC 10
`define ISP_B_MT4 9
`define ISP_B_MT3 8
`define ISP_B_TM2 7
`define ISP_B_PT1 6
`define ISP_B_PT0 5
`define ISP_B_CMT 4
`define ISP_B_OL 2
`define ISP_B_OSC 1
`define ISP_B_FT 0
// misc control bits
`define ISP_M_KEYEN 15
`define ISP_M_E1EDGE 14
`define ISP_M_E0EDGE 13
`define ISP_M_E1EN 12
`define ISP_M_E0EN 11
// pin filter: pulses shorter than this many sample ticks are dropped
`define ISP_FILT_TICKS 4
`define ISP_FILT_DIV 2

`endif

// ---- design/isp_pin_filter.v ----
// glitch filter and edge detector for one external interrupt pin
// assumes the pin is synchronous to clock and sample_en pulses every
// second clock
`timescale 1ns/10ps
`default_nettype none
`include "isp_defines.vh"

module isp_pin_filter #(
  parameter TICKS = `ISP_FILT_TICKS
) (
  input wire clock, // system clock
  input wire rst_n, // synchronous reset, active low
  input wire sample_en, // one-cycle sample tick
  input wire pin, // raw pin level
  input wire rise_sel, // 1 rising edge, 0 falling edge
  output reg edge_q // one-cycle pulse on qualified edge
);
  reg [2:0] cnt_q;
  reg level_q;
  reg pin_q;

  // level changes only after the pin holds a new value for TICKS samples
  always @(posedge clock) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      level_q <= 1'b0;
      pin_q <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      edge_q <= 1'b0;
      if (sample_en) begin
        pin_q <= pin;
        if (pin_q == level_q) begin
          cnt_q <= 3'h0;
        end else if (cnt_q == TICKS[2:0] - 3'h1) begin
          cnt_q <= 3'h0;
          level_q <= pin_q;
          edge_q <= (pin_q == rise_sel);
        end else begin
          cnt_q <= cnt_q + 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/isp_irq_ctrl.v ----
// interrupt status, fast-route select and pin interrupt control
// assumes peripheral flags are levels held in the peripherals' own
// registers, pins synchronous to clock, and a core that stacks state
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "isp_defines.vh"

module isp_irq_ctrl #(
  parameter AW = 16,
  parameter DW = 16
) (
  input wire clock, // 200 MHz system clock
  input wire rst_n, // synchronous reset, active low
  input wire [AW-1:0] addr, // register address
  input wire [DW-1:0] wdata, // write data
  input wire wr, // write strobe
  input wire rd, // read strobe
  output reg [DW-1:0] rdata_q, // read data, cycle after rd
  input wire key_change_event, // key change pulse from port
  input wire ext_irq_pin1, // external interrupt pin 1
  input wire ext_irq_pin0, // external interrupt pin 0
  input wire serial_async_flag, // uart flag and its enable
  input wire serial_sync_flag, // spi flag and its enable
  input wire converter_done_flag, // converter flag and enable
  input wire motor_timer4_flag, // motor timer 4 flag and enable
  input wire motor_timer3_flag, // motor timer 3 flag and enable
  input wire timer2_flag, // timer 2 flag and enable
  input wire position_timer1_flag, // position timer 1 flag and enable
  input wire position_timer0_flag, // position timer 0 flag and enable
  input wire compare_match_flag, // compare timer flag and enable
  input wire overload_flag, // overload flag and enable
  input wire osc_stopped, // clock monitor: oscillator stopped
  input wire fault_input1, // fault pin 1 flag
  input wire fault_input2, // fault pin 2 flag
  input wire short_timer3, // timer 3 outputs short flag
  input wire short_timer4, // timer 4 outputs short flag
  input wire fault_enable, // fault interrupt enable of protection
  input wire osc_fail_enable, // oscillator fail interrupt enable
  output reg fast_interrupt_request_q, // fast request to core
  output reg [7:0] irq_level_q, // numbered requests, bit n = level n
  output reg [3:0] irq_top_level_q, // highest priority pending level
  output reg irq_any_q // any numbered request pending
);
  reg [15:0] route_q;
  reg [15:0] misc_q;
  reg key_flag_q, ext1_flag_q, ext0_flag_q;
  reg [15:0] status;
  reg [15:0] req;
  reg [7:0] lvl_d;
  reg fast_d;
  reg [3:0] top_d;
  reg div_q;
  wire ext1_edge, ext0_edge;
  wire wr_status = wr && (addr == `ISP_ADDR_STATUS);
  wire wr_route = wr && (addr == `ISP_ADDR_ROUTE);
  wire wr_misc = wr && (addr == `ISP_ADDR_MISC);
  integer i;

  // sample tick at half the clock rate
  always @(posedge clock) begin
    if (!rst_n) begin
      div_q <= 1'b0;
    end else begin
      div_q <= ~div_q;
    end
  end

  isp_pin_filter #(.TICKS(`ISP_FILT_TICKS)) u_filt1 (
    .clock(clock),
    .rst_n(rst_n),
    .sample_en(div_q),
    .pin(ext_irq_pin1),
    .rise_sel(misc_q[`ISP_M_E1EDGE]),
    .edge_q(ext1_edge)
  );

  isp_pin_filter #(.TICKS(`ISP_FILT_TICKS)) u_filt0 (
    .clock(clock),
    .rst_n(rst_n),
    .sample_en(div_q),
    .pin(ext_irq_pin0),
    .rise_sel(misc_q[`ISP_M_E0EDGE]),
    .edge_q(ext0_edge)
  );

  // local sticky flags; an event in the clear cycle wins
  always @(posedge clock) begin
    if (!rst_n) begin
      key_flag_q <= 1'b0;
      ext1_flag_q <= 1'b0;
      ext0_flag_q <= 1'b0;
    end else begin
      // flags set regardless of enables so software can poll
      key_flag_q <= key_change_event |
        (key_flag_q & ~(wr_status & wdata[`ISP_B_KEY]));
      ext1_flag_q <= ext1_edge |
        (ext1_flag_q & ~(wr_status & wdata[`ISP_B_EXT1]));
      ext0_flag_q <= ext0_edge |
        (ext0_flag_q & ~(wr_status & wdata[`ISP_B_EXT0]));
    end
  end

  // control registers; read-only bits stay zero
  always @(posedge clock) begin
    if (!rst_n) begin
      route_q <= `ISP_ROUTE_RST;
      misc_q <= `ISP_MISC_RST;
    end else begin
      if (wr_route) begin
        route_q <= wdata & `ISP_ROUTE_WMASK;
      end
      if (wr_misc) begin
        misc_q <= wdata & `ISP_MISC_WMASK;
      end
    end
  end

  // summary word; peripheral flags are live copies
  always @* begin
    status = 16'h0000;
    status[`ISP_B_KEY] = key_flag_q;
    status[`ISP_B_UART] = serial_async_flag;
    status[`ISP_B_SPI] = serial_sync_flag;
    status[`ISP_B_EXT1] = ext1_flag_q;
    status[`ISP_B_EXT0] = ext0_flag_q;
    status[`ISP_B_ADC] = converter_done_flag;
    status[`ISP_B_MT4] = motor_timer4_flag;
    status[`ISP_B_MT3] = motor_timer3_flag;
    status[`ISP_B_TM2] = timer2_flag;
    status[`ISP_B_PT1] = position_timer1_flag;
    status[`ISP_B_PT0] = position_timer0_flag;
    status[`ISP_B_CMT] = compare_match_flag;
    status[`ISP_B_OL] = overload_flag;
    status[`ISP_B_OSC] = osc_stopped;
    status[`ISP_B_FT] = fault_input1 | fault_input2 |
      short_timer3 | short_timer4;
  end

  // gate the key, pin, oscillator and fault flags with their enables
  always @* begin
    req = status;
    req[`ISP_B_KEY] = status[`ISP_B_KEY] & misc_q[`ISP_M_KEYEN];
    req[`ISP_B_EXT1] = status[`ISP_B_EXT1] & misc_q[`ISP_M_E1EN];
    req[`ISP_B_EXT0] = status[`ISP_B_EXT0] & misc_q[`ISP_M_E0EN];
    req[`ISP_B_OSC] = status[`ISP_B_OSC] & osc_fail_enable;
    req[`ISP_B_FT] = status[`ISP_B_FT] & fault_enable;
  end

  // route groups to fast request or default levels
  always @* begin
    // pin 1 has no route bit of its own; it follows the shared pin bit
    fast_d = |(req & route_q) |
      (req[`ISP_B_EXT1] & route_q[`ISP_B_EXT0]);
    lvl_d = 8'h00;
    lvl_d[7] = (req[`ISP_B_KEY] & ~route_q[`ISP_B_KEY]) |
      (req[`ISP_B_ADC] & ~route_q[`ISP_B_ADC]) |
      (req[`ISP_B_CMT] & ~route_q[`ISP_B_CMT]);
    lvl_d[6] = (req[`ISP_B_UART] & ~route_q[`ISP_B_UART]) |
      (req[`ISP_B_SPI] & ~route_q[`ISP_B_SPI]);
    // both pins share one route bit
    lvl_d[5] = (req[`ISP_B_EXT1] | req[`ISP_B_EXT0]) &
      ~route_q[`ISP_B_EXT0];
    lvl_d[4] = req[`ISP_B_TM2] & ~route_q[`ISP_B_TM2];
    lvl_d[3] = (req[`ISP_B_MT4] & ~route_q[`ISP_B_MT4]) |
      (req[`ISP_B_MT3] & ~route_q[`ISP_B_MT3]);
    lvl_d[2] = req[`ISP_B_PT1] & ~route_q[`ISP_B_PT1];
    lvl_d[1] = req[`ISP_B_PT0] & ~route_q[`ISP_B_PT0];
    lvl_d[0] = (req[`ISP_B_OL] & ~route_q[`ISP_B_OL]) |
      (req[`ISP_B_OSC] & ~route_q[`ISP_B_OSC]) |
      (req[`ISP_B_FT] & ~route_q[`ISP_B_FT]);
  end

  // 4'h8 encodes fast; otherwise the lowest-numbered level pending
  always @* begin
    top_d = 4'hf;
    for (i = 7; i >= 0; i = i - 1) begin
      if (lvl_d[i]) begin
        top_d = i[3:0];
      end
    end
    if (fast_d) begin
      top_d = 4'h8;
    end
  end

  // registered outputs; the core stacks its own state on entry
  always @(posedge clock) begin
    if (!rst_n) begin
      fast_interrupt_request_q <= 1'b0;
      irq_level_q <= 8'h00;
      irq_top_level_q <= 4'hf;
      irq_any_q <= 1'b0;
    end else begin
      fast_interrupt_request_q <= fast_d;
      irq_level_q <= lvl_d;
      irq_top_level_q <= top_d;
      irq_any_q <= |lvl_d;
    end
  end

  // read port; unmapped addresses read zero
  always @(posedge clock) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `ISP_ADDR_STATUS: rdata_q <= status;
        `ISP_ADDR_ROUTE: rdata_q <= route_q;
        `ISP_ADDR_MISC: rdata_q <= misc_q;
        default: rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ---- tb/isp_irq_chk.sv ----
// port checker for isp_irq_ctrl request and read-back behaviour
// assumes one clock domain and the constants of isp_defines.vh
`timescale 1ns/10ps
`default_nettype none
`include "isp_defines.vh"
module isp_irq_chk (
  input wire logic clock, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic osc_stopped, // clock monitor level
  input wire logic osc_fail_enable, // oscillator fail enable
  input wire logic timer2_flag, // timer 2 flag
  input wire logic serial_async_flag, // uart flag
  input wire logic irq_any_q, // any numbered request
  input wire logic fast_interrupt_request_q, // fast request
  input wire logic [15:0] addr, // register address
  input wire logic [15:0] wdata, // write data
  input wire logic [15:0] rdata_q, // read data
  input wire logic [7:0] irq_level_q, // numbered requests
  input wire logic [3:0] irq_top_level_q // presented level
);
  logic [15:0] route_q;
  logic [2:0] ho_q, ht_q, hu_q;
  wire logic fq = fast_interrupt_request_q;
  wire logic [3:0] tp = irq_top_level_q;
  // three cycles of history cover a flag that passes one register
  always @(posedge clock) begin
    if (!rst_n) begin
      route_q <= 16'h0000;
      ho_q <= 3'h0;
      ht_q <= 3'h0;
      hu_q <= 3'h0;
    end else begin
      if (wr && addr == `ISP_ADDR_ROUTE)
        route_q <= wdata & `ISP_ROUTE_WMASK;
      ho_q <= {ho_q[1:0], osc_stopped & osc_fail_enable & !route_q[1]};
      ht_q <= {ht_q[1:0], timer2_flag & !route_q[7]};
      hu_q <= {hu_q[1:0], serial_async_flag & !route_q[14]};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_fast_top;
    fq |-> tp == 4'h8;
  endproperty
  a_fast_top: assert property (p_fast_top) else $error("fast");
  property p_low_top;
    !fq && irq_any_q |-> !tp[3] && irq_level_q[tp[2:0]] &&
      (irq_level_q & ((8'h01 << tp[2:0]) - 8'h01)) == 8'h00;
  endproperty
  a_low_top: assert property (p_low_top) else $error("low");
  property p_none;
    !fq && !irq_any_q |-> tp == 4'hf && irq_level_q == 8'h00;
  endproperty
  a_none: assert property (p_none) else $error("none");
  property p_no_fast;
    route_q == 16'h0000 && $past(route_q) == 16'h0000 |-> !fq;
  endproperty
  a_no_fast: assert property (p_no_fast) else $error("fq");
  property p_osc_l0;
    ho_q == 3'h7 |-> irq_level_q[0];
  endproperty
  a_osc_l0: assert property (p_osc_l0) else $error("osc");
  property p_tm2_l4;
    ht_q == 3'h7 |-> irq_level_q[4];
  endproperty
  a_tm2_l4: assert property (p_tm2_l4) else $error("tm2");
  property p_uart_l6;
    hu_q == 3'h7 |-> irq_level_q[6];
  endproperty
  a_uart_l6: assert property (p_uart_l6) else $error("uart");
  property p_misc_rsv;
    rd && addr == `ISP_ADDR_MISC |=> rdata_q[10:0] == 11'h000;
  endproperty
  a_misc_rsv: assert property (p_misc_rsv) else $error("misc");
endmodule
bind isp_irq_ctrl isp_irq_chk u_chk (.*);
`default_nettype wire

// ---- tb/isp_core_model.sv ----
// core-side model: enters the presented request, stacks, returns
// assumes the request outputs of isp_irq_ctrl on the same clock
`timescale 1ns/10ps
`default_nettype none
module isp_core_model (
  input wire logic clock, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic fast_req, // fast request
  input wire logic any_req, // any numbered request
  input wire logic [3:0] top_level, // request presented
  output var logic [3:0] taken // last request entered
);
  logic [15:0] stack[$];
  always @(posedge clock) begin
    if (!rst_n) begin
      taken <= 4'hf;
      stack.delete();
    end else if (stack.size() != 0) begin
      stack.delete();
    end else if (fast_req || any_req) begin
      stack.push_back(16'h0100);
      stack.push_back({12'h000, top_level});
      taken <= top_level;
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for isp_irq_ctrl against a reference model
// assumes isp_defines.vh and the core model beside it
`timescale 1ns/10ps
`default_nettype none
`include "isp_defines.vh"
module testbench;
  logic clock, rst_n, wr, rd, kev, pin1, pin0, oen, fen;
  logic [15:0] addr, wdata, pv, rdata_q;
  logic [3:0] fv, top, taken;
  logic [7:0] lvl;
  logic fast, any;
  int seed = 63203;
  int num_errors = 0, checked = 0, i, p, s;
  int route = 0, misc = 0, flg = 0;
  int lv_of[16] = '{0, 0, 0, 0, 7, 1, 2, 4, 3, 3, 7, 5, 5, 6, 6, 7};
  isp_irq_ctrl dut (.clock(clock), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
    .key_change_event(kev), .ext_irq_pin1(pin1), .ext_irq_pin0(pin0),
    .serial_async_flag(pv[14]), .serial_sync_flag(pv[13]),
    .converter_done_flag(pv[10]), .motor_timer4_flag(pv[9]),
    .motor_timer3_flag(pv[8]), .timer2_flag(pv[7]),
    .position_timer1_flag(pv[6]), .position_timer0_flag(pv[5]),
    .compare_match_flag(pv[4]), .overload_flag(pv[2]),
    .osc_stopped(pv[1]), .fault_input1(fv[0]), .fault_input2(fv[1]),
    .short_timer3(fv[2]), .short_timer4(fv[3]), .fault_enable(fen),
    .osc_fail_enable(oen), .fast_interrupt_request_q(fast),
    .irq_level_q(lvl), .irq_top_level_q(top), .irq_any_q(any));
  isp_core_model core (.clock(clock), .rst_n(rst_n), .fast_req(fast),
    .any_req(any), .top_level(top), .taken(taken));
  task chk(input string n, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task wreg(input logic [15:0] a, d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    if (a == `ISP_ADDR_ROUTE) route = d & `ISP_ROUTE_WMASK;
    if (a == `ISP_ADDR_MISC) misc = d & `ISP_MISC_WMASK;
    if (a == `ISP_ADDR_STATUS) flg &= ~(d & `ISP_STATUS_W1C);
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task rreg(input logic [15:0] a, exp, input string n);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(n, rdata_q, exp);
  endtask
  task setpin(input int v, n);
    @(posedge clock);
    if (p == 1) pin1 <= v[0];
    else pin0 <= v[0];
    repeat (n - 1) @(posedge clock);
  endtask
  task chk_all;
    int st, pend, fq, lv, tp;
    st = (pv & 16'h67f6) | flg | ((fv != 4'h0) ? 1 : 0);
    pend = (st & 'h67f4) | (st & misc & 'h9800) | (st & {oen, fen});
    fq = 0;
    lv = 0;
    for (int k = 0; k < 16; k++) begin
      if (pend[k] && route[(k == 12) ? 11 : k]) fq = 1;
      else if (pend[k]) lv |= 1 << lv_of[k];
    end
    tp = fq ? 8 : 15;
    for (int k = 7; k >= 0; k--) if (!fq && lv[k]) tp = k;
    repeat (3) @(posedge clock);
    rreg(`ISP_ADDR_STATUS, st, "status");
    chk("fast", fast, fq);
    chk("level", lvl, lv);
    chk("top", top, tp);
    chk("any", any, lv != 0);
    if (tp != 15) chk("core", taken, tp);
  endtask
  task end_sim;
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    num_errors++;
    end_sim;
  end
  initial begin
    {rst_n, wr, rd, kev, pin1, pin0, oen, fen} = 8'h00;
    {addr, wdata, pv, fv} = 52'h0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rreg(`ISP_ADDR_ROUTE, 16'h0000, "route");
    rreg(`ISP_ADDR_MISC, 16'h0000, "misc");
    rreg(16'h70a2, 16'h0000, "unmapped");
    for (i = 0; i < 24; i++) begin
      @(posedge clock);
      pv <= 16'($random(seed)) & 16'h67f6;
      fv <= 4'($random(seed));
      {oen, fen} <= 2'($random(seed));
      kev <= i[0];
      if (i[0]) flg |= 'h8000;
      @(posedge clock);
      kev <= 1'b0;
      wreg(`ISP_ADDR_MISC, 16'($random(seed)));
      wreg(`ISP_ADDR_ROUTE, 16'h0001 << ($random(seed) & 15));
      chk_all;
      rreg(`ISP_ADDR_ROUTE, route, "route");
      rreg(`ISP_ADDR_MISC, misc, "misc");
      wreg(`ISP_ADDR_STATUS, 16'($random(seed)));
      chk_all;
    end
    for (i = 0; i < 4; i++) begin
      s = i % 2;
      p = i / 2;
      wreg(`ISP_ADDR_MISC, 16'h1800 | 16'(s << (13 + p)));
      wreg(`ISP_ADDR_ROUTE, 16'(p << `ISP_B_EXT0));
      setpin(!s, 24);
      wreg(`ISP_ADDR_STATUS, 16'h1800);
      setpin(s, 6);
      setpin(!s, 24);
      chk_all;
      setpin(s, 24);
      flg |= 'h800 << p;
      chk_all;
    end
    end_sim;
  end
endmodule
`default_nettype wire
